/* logic/uafc_pkg.sv */
// Package of constants and carrier types for the autoflow and modem host block
package uafc_pkg;

  // Register select codes
  localparam logic [2:0] OFS_RX_BUF     = 3'h0;
  localparam logic [2:0] OFS_INT_EN     = 3'h1;
  localparam logic [2:0] OFS_FIFO_CTL   = 3'h2;
  localparam logic [2:0] OFS_LINE_CTL   = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTL  = 3'h4;
  localparam logic [2:0] OFS_MODEM_STAT = 3'h6;

  // Field positions
  localparam int LCR_DIV_BIT      = 7;
  localparam int IER_MSI_BIT      = 3;
  localparam int FCR_TRIG_LSB     = 6;
  localparam int MCR_DTR_BIT      = 0;
  localparam int MCR_RTS_BIT      = 1;
  localparam int MCR_LOOP_BIT     = 4;
  localparam int MCR_AUTOFLOW_BIT = 5;
  localparam int MSR_DCTS_BIT     = 0;
  localparam int MSR_DDSR_BIT     = 1;
  localparam int MSR_DDCD_BIT     = 3;
  localparam int MSR_CTS_BIT      = 4;
  localparam int MSR_DSR_BIT      = 5;
  localparam int MSR_DCD_BIT      = 7;

  // Reset values
  localparam logic [7:0]  REG8_RST = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0001;

  // Receive queue sizing
  localparam int         RXQ_DEPTH = 16;
  localparam logic [4:0] RXQ_FULL  = 5'h10;
  localparam logic [4:0] RXQ_LAST  = 5'h0F;

  typedef enum logic [1:0] {
    UAFC_TRIG_1  = 2'b00,
    UAFC_TRIG_4  = 2'b01,
    UAFC_TRIG_8  = 2'b10,
    UAFC_TRIG_14 = 2'b11
  } uafc_trig_e;

  // Host and modem pins, all from outside the clock domain
  typedef struct packed {
    logic       reg_sel_bit2;
    logic       reg_sel_bit1;
    logic       reg_sel_bit0;
    logic       chip_sel_hi_a;
    logic       chip_sel_hi_b;
    logic       chip_sel_lo;
    logic       select_latch_strobe;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] data;
    logic       cts_n;
    logic       dsr_n;
    logic       dcd_n;
  } uafc_pins_s;

  // Receiver status, same clock
  typedef struct packed {
    logic       push;
    logic       first_data;
    logic       busy;
    logic [7:0] data;
  } uafc_rx_s;

  // Transmitter status, same clock
  typedef struct packed {
    logic busy;
    logic stop_mid;
  } uafc_tx_s;

endpackage

/* logic/uafc_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module uafc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '1;
      q        <= '1;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // uafc_sync
`default_nettype wire

/* logic/uafc_baud.sv */
// Baud divider giving the transmitter 16x clock
`timescale 1ns/10ps
`default_nettype none
module uafc_baud (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Divisor
  input  wire logic [15:0] divisor,
  // Clock out
  output var  logic        clk_out
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] div_eff;

  assign div_eff = (divisor == 16'h0000) ? 16'h0001 : divisor;

  always_comb begin
    if (cnt_reg >= div_eff - 16'h0001) begin
      cnt_next = 16'h0000;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  // Rate is clock over divisor
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 16'h0000;
      clk_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      clk_out <= {1'b0, cnt_next} < (({1'b0, div_eff} + 17'h0_0001) >> 1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_baud_wrap;
    (cnt_reg == div_eff - 16'h0001) && $stable(divisor) |=> cnt_reg == 16'h0000;
  endproperty
  a_baud_wrap: assert property (p_baud_wrap)
    else $error("baud counter did not wrap at divisor");

  property p_baud_rise;
    $rose(clk_out) |-> cnt_reg == 16'h0000;
  endproperty
  a_baud_rise: assert property (p_baud_rise)
    else $error("baud clock rose away from period start");
endmodule // uafc_baud
`default_nettype wire

/* logic/uafc_core.sv */
// Autoflow control, modem status and host pin logic of the serial controller
// Overview of operation
// - With auto clear-to-send, keep transmitting while clear-to-send is low.
// - Clear-to-send high before mid last stop bit: finish character, start no more.
// - Clear-to-send back low resumes sending pending characters.
// - Receive trigger level selectable as 1, 4, 8 or 14 bytes.
// - At levels 1, 4, 8 one extra character after withdrawal is stored.
// - Level 14: drop request-to-send at first data bit of sixteenth character.
// - Level 14: raise again if one free and idle, or more free.
// - Level 14, queue full: first receive buffer read raises request-to-send.
// - Selects pass while strobe low, held from its rising edge.
// - 16x clock out equals reference clock over divisor latch.
// - Selected only with both high selects high and low select low.
// - Status bit 4 shows clear-to-send, bit 0 flags its change.
// - Clear-to-send change interrupts only if enabled and auto mode off.
// - Status bit 7 shows carrier, bit 3 flags change, may interrupt.
// - Status bit 5 shows data-set-ready, bit 1 flags change, may interrupt.
// - Eight-bit three-state data bus to the host.
// - Transceiver disable high whenever host is not reading.
// - Terminal-ready output active low when its control bit is set.
// - Terminal-ready inactive at reset, in loopback, or bit cleared.
// - Control bits 5 and 1 give full autoflow; bit 5 only gives auto-CTS.
// - Levels 1, 4, 8: drop at trigger level, raise once queue empty.
`timescale 1ns/10ps
`default_nettype none
module uafc_core (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Host and modem pins
  input  wire uafc_pkg::uafc_pins_s pins_in,
  output var  logic [7:0]          data_out,
  output var  logic                data_oe,
  output var  logic                xcvr_disable_out,
  // Modem outputs
  output var  logic                dtr_n_out,
  output var  logic                rts_n_out,
  output var  logic                modem_irq,
  output var  logic                tx_16x_clock_out,
  // Receiver and transmitter
  input  wire uafc_pkg::uafc_rx_s   rx,
  input  wire uafc_pkg::uafc_tx_s   tx,
  output var  logic                tx_go
);
  import uafc_pkg::*;

  uafc_pins_s  pins_s;
  logic [5:0]  sel_hold_reg;
  logic [5:0]  sel_live;
  logic [5:0]  sel_eff;
  logic [2:0]  addr;
  logic        selected;
  logic        rd_act;
  logic        wr_act;
  logic        rd_prev_reg;
  logic        wr_prev_reg;
  logic        rd_pulse;
  logic        wr_pulse;
  logic [7:0]  ie_reg;
  logic [7:0]  lcr_reg;
  logic [7:0]  mcr_reg;
  logic [15:0] div_reg;
  uafc_trig_e  trig_reg;
  logic        dlab;
  logic        auto_cts;
  logic        auto_rts;
  logic [2:0]  mst_now;
  logic [2:0]  mst_prev_reg;
  logic [2:0]  chg;
  logic [2:0]  delta_reg;
  logic [7:0]  msr;
  logic        msr_read;
  logic [7:0]  rxq_mem [RXQ_DEPTH];
  logic [3:0]  wr_ptr_reg;
  logic [3:0]  rd_ptr_reg;
  logic [4:0]  cnt_reg;
  logic        push;
  logic        pop;
  logic        rts_auto_reg;

  // Selection level decode
  function automatic logic chip_on(input logic [5:0] s);
    return s[2] && s[1] && !s[0];
  endfunction

  // Trigger level in bytes
  function automatic logic [4:0] trig_level(input uafc_trig_e t);
    case (t)
      UAFC_TRIG_1: return 5'h01;
      UAFC_TRIG_4: return 5'h04;
      UAFC_TRIG_8: return 5'h08;
      default:     return 5'h0E;
    endcase
  endfunction

  uafc_sync #(.WIDTH($bits(uafc_pins_s))) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (pins_in),
    .q       (pins_s)
  );

  uafc_baud u_baud (
    .clk     (clk),
    .reset_n (reset_n),
    .divisor (div_reg),
    .clk_out (tx_16x_clock_out)
  );

  // Select latch and chip decode
  assign sel_live = {pins_s.reg_sel_bit2, pins_s.reg_sel_bit1, pins_s.reg_sel_bit0,
                     pins_s.chip_sel_hi_a, pins_s.chip_sel_hi_b, pins_s.chip_sel_lo};
  assign sel_eff  = pins_s.select_latch_strobe ? sel_hold_reg : sel_live;
  assign addr     = sel_eff[5:3];
  assign selected = chip_on(sel_eff);
  assign rd_act   = selected && !pins_s.rd_n;
  assign wr_act   = selected && !pins_s.wr_n;
  assign rd_pulse = rd_act && !rd_prev_reg;
  assign wr_pulse = wr_act && !wr_prev_reg;
  assign dlab     = lcr_reg[LCR_DIV_BIT];
  assign auto_cts = mcr_reg[MCR_AUTOFLOW_BIT];
  assign auto_rts = mcr_reg[MCR_AUTOFLOW_BIT] && mcr_reg[MCR_RTS_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_hold_reg <= 6'h00;
    end else if (!pins_s.select_latch_strobe) begin
      sel_hold_reg <= sel_live;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
    end else begin
      rd_prev_reg <= rd_act;
      wr_prev_reg <= wr_act;
    end
  end

  // Register writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ie_reg   <= REG8_RST;
      lcr_reg  <= REG8_RST;
      mcr_reg  <= REG8_RST;
      div_reg  <= DIV_RST;
      trig_reg <= UAFC_TRIG_1;
    end else if (wr_pulse) begin
      case (addr)
        OFS_RX_BUF:    if (dlab) div_reg[7:0] <= pins_s.data;
        OFS_INT_EN: begin
          if (dlab) begin
            div_reg[15:8] <= pins_s.data;
          end else begin
            ie_reg <= pins_s.data;
          end
        end
        OFS_FIFO_CTL:  trig_reg <= uafc_trig_e'(pins_s.data[FCR_TRIG_LSB +: 2]);
        OFS_LINE_CTL:  lcr_reg <= pins_s.data;
        OFS_MODEM_CTL: mcr_reg <= pins_s.data;
        default: ;
      endcase
    end
  end

  // Modem status and change flags
  assign mst_now  = {~pins_s.dcd_n, ~pins_s.dsr_n, ~pins_s.cts_n};
  assign chg      = mst_now ^ mst_prev_reg;
  assign msr_read = rd_pulse && (addr == OFS_MODEM_STAT);
  always_comb begin
    msr               = 8'h00;
    msr[MSR_DCTS_BIT] = delta_reg[0];
    msr[MSR_DDSR_BIT] = delta_reg[1];
    msr[MSR_DDCD_BIT] = delta_reg[2];
    msr[MSR_CTS_BIT]  = mst_now[0];
    msr[MSR_DSR_BIT]  = mst_now[1];
    msr[MSR_DCD_BIT]  = mst_now[2];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mst_prev_reg <= 3'h0;
      delta_reg    <= 3'h0;
    end else begin
      mst_prev_reg <= mst_now;
      delta_reg    <= (delta_reg & ~{3{msr_read}}) | chg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modem_irq <= 1'b0;
    end else begin
      modem_irq <= ie_reg[IER_MSI_BIT] && ((delta_reg[0] && !auto_cts)
                   || delta_reg[1] || delta_reg[2]);
    end
  end

  // Host data bus
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out         <= 8'h00;
      data_oe          <= 1'b0;
      xcvr_disable_out <= 1'b1;
    end else begin
      data_oe          <= rd_act;
      xcvr_disable_out <= !rd_act;
      if (rd_pulse) begin
        case (addr)
          OFS_RX_BUF:     data_out <= dlab ? div_reg[7:0] : rxq_mem[rd_ptr_reg];
          OFS_INT_EN:     data_out <= dlab ? div_reg[15:8] : ie_reg;
          OFS_LINE_CTL:   data_out <= lcr_reg;
          OFS_MODEM_CTL:  data_out <= mcr_reg;
          OFS_MODEM_STAT: data_out <= msr;
          default:        data_out <= 8'h00;
        endcase
      end
    end
  end

  // Modem control outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dtr_n_out <= 1'b1;
      rts_n_out <= 1'b1;
    end else begin
      dtr_n_out <= !(mcr_reg[MCR_DTR_BIT] && !mcr_reg[MCR_LOOP_BIT]);
      rts_n_out <= auto_rts ? !rts_auto_reg : !mcr_reg[MCR_RTS_BIT];
    end
  end

  // Receive queue
  assign push = rx.push && (cnt_reg != RXQ_FULL);
  assign pop  = rd_pulse && (addr == OFS_RX_BUF) && !dlab && (cnt_reg != 5'h00);

  always_ff @(posedge clk) begin
    if (push) begin
      rxq_mem[wr_ptr_reg] <= rx.data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      cnt_reg    <= 5'h00;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 4'h1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 4'h1;
      cnt_reg <= cnt_reg + {4'h0, push} - {4'h0, pop};
    end
  end

  // Automatic request-to-send
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rts_auto_reg <= 1'b1;
    end else if (trig_reg == UAFC_TRIG_14) begin
      if (rx.first_data && cnt_reg == RXQ_LAST) begin
        rts_auto_reg <= 1'b0;
      end else if (pop && cnt_reg == RXQ_FULL) begin
        rts_auto_reg <= 1'b1;
      end else if (cnt_reg < RXQ_LAST || (cnt_reg == RXQ_LAST && !rx.busy)) begin
        rts_auto_reg <= 1'b1;
      end
    end else begin
      if (cnt_reg >= trig_level(trig_reg)) begin
        rts_auto_reg <= 1'b0;
      end else if (cnt_reg == 5'h00) begin
        rts_auto_reg <= 1'b1;
      end
    end
  end

  // Transmit start gate
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_go <= 1'b1;
    end else if (!auto_cts) begin
      tx_go <= 1'b1;
    end else if (tx.busy) begin
      if (tx.stop_mid) tx_go <= mst_now[0];
    end else begin
      tx_go <= mst_now[0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_tx_run;
    auto_cts && !tx.busy && mst_now[0] |=> tx_go;
  endproperty
  a_tx_run: assert property (p_tx_run)
    else $error("transmit gate closed while clear-to-send active");

  property p_tx_stop;
    auto_cts && tx.busy && tx.stop_mid && !mst_now[0] |=> !tx_go;
  endproperty
  a_tx_stop: assert property (p_tx_stop)
    else $error("transmit gate open after late clear-to-send release");

  property p_tx_hold;
    auto_cts && tx.busy && !tx.stop_mid ##1 auto_cts |-> $stable(tx_go);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit gate changed mid character");

  property p_rts14_off;
    auto_rts && trig_reg == UAFC_TRIG_14 && rx.first_data && cnt_reg == RXQ_LAST
      |=> !rts_auto_reg ##1 rts_n_out || !auto_rts;
  endproperty
  a_rts14_off: assert property (p_rts14_off)
    else $error("request-to-send not dropped at sixteenth character");

  property p_full_read;
    trig_reg == UAFC_TRIG_14 && pop && cnt_reg == RXQ_FULL |=> rts_auto_reg;
  endproperty
  a_full_read: assert property (p_full_read)
    else $error("read of full queue did not raise request-to-send");

  property p_rts_low_off;
    trig_reg != UAFC_TRIG_14 && $stable(trig_reg) && cnt_reg >= trig_level(trig_reg)
      |=> !rts_auto_reg;
  endproperty
  a_rts_low_off: assert property (p_rts_low_off)
    else $error("request-to-send not dropped at trigger level");

  property p_msr_clear;
    msr_read |=> delta_reg == $past(chg);
  endproperty
  a_msr_clear: assert property (p_msr_clear)
    else $error("status read did not clear change flags");

  property p_irq_cts;
    delta_reg[0] && ie_reg[IER_MSI_BIT] && !auto_cts |=> modem_irq;
  endproperty
  a_irq_cts: assert property (p_irq_cts)
    else $error("clear-to-send change did not interrupt");

  property p_dtr_loop;
    mcr_reg[MCR_LOOP_BIT] |=> dtr_n_out;
  endproperty
  a_dtr_loop: assert property (p_dtr_loop)
    else $error("terminal-ready active in loopback");

  property p_xcvr_disable_out;
    !rd_act |=> xcvr_disable_out && !data_oe;
  endproperty
  a_xcvr_disable_out: assert property (p_xcvr_disable_out)
    else $error("transceiver disable low without a read");

  property p_sel_hold;
    pins_s.select_latch_strobe && $past(pins_s.select_latch_strobe) |-> $stable(sel_hold_reg);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("select latch moved while strobe high");

  c_full: cover property (cnt_reg == RXQ_FULL);
  c_rts_drop: cover property (auto_rts && $rose(rts_n_out));
  c_tx_pause: cover property (auto_cts && $fell(tx_go));
  c_msr_irq: cover property ($rose(modem_irq));
endmodule // uafc_core
`default_nettype wire

/* verif/uafc_remote.sv */
// Remote sender and local transmitter shifter model
`timescale 1ns/10ps
`default_nettype none
module uafc_remote #(
  parameter int CHAR = 12
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Remote sender
  input  wire logic              go,
  input  wire logic              obey,
  input  wire logic              rts_n,
  input  wire logic [7:0]        seed,
  output var  uafc_pkg::uafc_rx_s rx,
  output var  logic [7:0]        sent,
  // Local transmitter
  input  wire logic              tx_more,
  input  wire logic              tx_go,
  output var  uafc_pkg::uafc_tx_s tx,
  output var  logic [7:0]        tx_cnt
);
  import uafc_pkg::*;
  logic [4:0] rc_reg;
  logic [4:0] tc_reg;

  // Sender looks at request-to-send only when a character starts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rc_reg <= '0;
      sent   <= '0;
      rx     <= '0;
    end else begin
      rx.push       <= 1'b0;
      rx.first_data <= 1'b0;
      rx.data       <= ~rx.data;
      if (rc_reg != 5'd0) begin
        rc_reg <= rc_reg - 5'd1;
        if (rc_reg == 5'(CHAR - 1)) rx.first_data <= 1'b1;
        if (rc_reg == 5'd1) begin
          rx.push <= 1'b1;
          rx.busy <= 1'b0;
          rx.data <= seed + sent;
          sent    <= sent + 8'd1;
        end
      end else if (go && (!obey || !rts_n)) begin
        rc_reg  <= 5'(CHAR);
        rx.busy <= 1'b1;
      end
    end
  end

  // Transmitter shifter, starts only while the gate is open
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tc_reg <= '0;
      tx     <= '0;
      tx_cnt <= '0;
    end else begin
      tx.stop_mid <= 1'b0;
      if (tc_reg != 5'd0) begin
        tc_reg <= tc_reg - 5'd1;
        if (tc_reg == 5'd4) tx.stop_mid <= 1'b1;
        if (tc_reg == 5'd1) begin
          tx.busy <= 1'b0;
          tx_cnt  <= tx_cnt + 8'd1;
        end
      end else if (tx_more && tx_go) begin
        tc_reg  <= 5'(CHAR);
        tx.busy <= 1'b1;
      end
    end
  end
endmodule // uafc_remote
`default_nettype wire

/* verif/test_uart_autoflow_modem_host_if.sv */
// Self-checking bench for the autoflow and modem host block
`timescale 1ns/10ps
`default_nettype none
module test_uart_autoflow_modem_host_if;
  import uafc_pkg::*;
  logic       clk, reset_n, host_oe, go, obey, tx_more, hold;
  logic       data_oe, xcvr_disable_out, dtr_n_out, rts_n_out, modem_irq, tx_16x_clock_out, tx_go;
  logic [7:0] host_d, data_out, seed, sent, tx_cnt;
  logic [2:0] cs;
  uafc_pins_s pins, pins_w;
  uafc_rx_s   rx;
  uafc_tx_s   tx;
  int         fail_count, num_checks, nxt;
  logic [7:0]  mcr_tab [4] = '{8'h01, 8'h11, 8'h03, 8'h00};
  logic [2:0]  bad_cs [3]  = '{3'b010, 3'b100, 3'b111};
  logic [11:0] irq_tab [4] = '{12'hA00, 12'hC00, 12'h120, 12'h900};

  uafc_core dut (.clk(clk), .reset_n(reset_n), .pins_in(pins_w), .data_out(data_out),
    .data_oe(data_oe), .xcvr_disable_out(xcvr_disable_out), .dtr_n_out(dtr_n_out),
    .rts_n_out(rts_n_out), .modem_irq(modem_irq), .tx_16x_clock_out(tx_16x_clock_out),
    .rx(rx), .tx(tx), .tx_go(tx_go));
  uafc_remote #(.CHAR(12)) remote (.clk(clk), .reset_n(reset_n), .go(go), .obey(obey),
    .rts_n(rts_n_out), .seed(seed), .rx(rx), .sent(sent), .tx_more(tx_more),
    .tx_go(tx_go), .tx(tx), .tx_cnt(tx_cnt));

  // Shared data bus with pull-up
  always_comb begin
    pins_w      = pins;
    pins_w.data = data_oe ? data_out : (host_oe ? host_d : 8'hFF);
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One host access; selects held from the latch when hold is set
  task automatic acc(input logic rd, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    if (!hold) begin
      {pins.reg_sel_bit2, pins.reg_sel_bit1, pins.reg_sel_bit0} <= a;
      {pins.chip_sel_hi_a, pins.chip_sel_hi_b, pins.chip_sel_lo} <= cs;
    end
    pins.rd_n <= !rd;
    pins.wr_n <= rd;
    host_d    <= d;
    host_oe   <= !rd;
    repeat (5) @(posedge clk);
    #1;
    q = data_out;
    chk1(data_oe, rd && cs == 3'b110);
    chk1(xcvr_disable_out, !(rd && cs == 3'b110));
    @(posedge clk);
    pins.rd_n <= 1'b1;
    pins.wr_n <= 1'b1;
    host_oe   <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk1(xcvr_disable_out, 1'b1);
  endtask
  task automatic hwr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b0, a, d, q);
  endtask
  task automatic hrd(input logic [2:0] a, output logic [7:0] q);
    acc(1'b1, a, 8'h00, q);
  endtask

  // Expected status from old and new levels {dcd_n, dsr_n, cts_n}
  function automatic logic [7:0] msr_exp(input logic [2:0] was, input logic [2:0] now);
    logic [7:0] e;
    e               = 8'h00;
    e[MSR_DCD_BIT]  = !now[2];
    e[MSR_DSR_BIT]  = !now[1];
    e[MSR_CTS_BIT]  = !now[0];
    e[MSR_DDCD_BIT] = was[2] ^ now[2];
    e[MSR_DDSR_BIT] = was[1] ^ now[1];
    e[MSR_DCTS_BIT] = was[0] ^ now[0];
    return e;
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    logic [7:0] q;
    logic [2:0] lv, pv;
    logic       o;
    int         d, e1, e2, n, lvl;
    pins = '1;
    pins.select_latch_strobe = 1'b0;
    {reset_n, host_d, host_oe, go, obey, tx_more, seed, hold} = '0;
    cs = 3'b110;
    {fail_count, num_checks, nxt} = '0;
    d = $urandom(32'h6580);
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk1(dtr_n_out, 1'b1);
    chk1(tx_go & xcvr_disable_out & rts_n_out & !modem_irq, 1'b1);
    tend("reset");
    foreach (mcr_tab[i]) begin
      hwr(OFS_MODEM_CTL, mcr_tab[i]);
      chk1(dtr_n_out, !(mcr_tab[i][0] && !mcr_tab[i][4]));
      chk1(rts_n_out, !mcr_tab[i][1]);
    end
    foreach (bad_cs[i]) begin
      cs = bad_cs[i];
      hwr(OFS_MODEM_CTL, 8'h01);
      chk1(dtr_n_out, 1'b1);
      hrd(OFS_MODEM_CTL, q);
    end
    cs = 3'b110;
    @(posedge clk);
    {pins.reg_sel_bit2, pins.reg_sel_bit1, pins.reg_sel_bit0} <= OFS_MODEM_CTL;
    {pins.chip_sel_hi_a, pins.chip_sel_hi_b, pins.chip_sel_lo} <= 3'b110;
    repeat (4) @(posedge clk);
    pins.select_latch_strobe <= 1'b1;
    @(posedge clk);
    {pins.reg_sel_bit2, pins.reg_sel_bit1, pins.reg_sel_bit0} <= OFS_RX_BUF;
    {pins.chip_sel_hi_a, pins.chip_sel_hi_b, pins.chip_sel_lo} <= 3'b001;
    hold = 1'b1;
    hwr(OFS_RX_BUF, 8'h01);
    chk1(dtr_n_out, 1'b0);
    @(posedge clk);
    pins.select_latch_strobe <= 1'b0;
    hold = 1'b0;
    hwr(OFS_MODEM_CTL, 8'h00);
    tend("host pins");
    pv = 3'b111;
    hrd(OFS_MODEM_STAT, q);
    for (int i = 0; i < 6; i++) begin
      lv = (i == 0) ? 3'b000 : 3'($urandom);
      @(posedge clk);
      {pins.dcd_n, pins.dsr_n, pins.cts_n} <= lv;
      repeat (6) @(posedge clk);
      hrd(OFS_MODEM_STAT, q);
      chk8(q, msr_exp(pv, lv));
      hrd(OFS_MODEM_STAT, q);
      chk8(q, msr_exp(lv, lv));
      pv = lv;
    end
    hwr(OFS_INT_EN, 8'h08);
    foreach (irq_tab[i]) begin
      hwr(OFS_MODEM_CTL, irq_tab[i][7:0]);
      @(posedge clk);
      {pins.dcd_n, pins.dsr_n, pins.cts_n} <= pv ^ irq_tab[i][10:8];
      pv = pv ^ irq_tab[i][10:8];
      repeat (6) @(posedge clk);
      #1 chk1(modem_irq, irq_tab[i][11]);
      hrd(OFS_MODEM_STAT, q);
      chk1(modem_irq, 1'b0);
    end
    tend("modem status");
    d = 2 + ($urandom % 6);
    hwr(OFS_LINE_CTL, 8'h80);
    hwr(OFS_RX_BUF, 8'(d));
    hwr(OFS_INT_EN, 8'h00);
    hwr(OFS_LINE_CTL, 8'h00);
    {e1, e2} = '0;
    o = tx_16x_clock_out;
    for (int k = 1; k < 60; k++) begin
      @(posedge clk);
      #1;
      if (!o && tx_16x_clock_out) begin
        e1 = e2;
        e2 = k;
      end
      o = tx_16x_clock_out;
    end
    chk8(8'(e2 - e1), 8'(d));
    tend("baud");
    hwr(OFS_MODEM_CTL, 8'h22);
    seed = 8'($urandom);
    for (int t = 0; t < 3; t++) begin
      lvl = (t == 0) ? 1 : 4 * t;
      hwr(OFS_FIFO_CTL, {2'(t), 6'h01});
      chk1(rts_n_out, 1'b0);
      @(posedge clk);
      go   <= 1'b1;
      obey <= 1'b1;
      for (n = 0; n < 400 && rts_n_out !== 1'b1; n++) @(posedge clk);
      go <= 1'b0;
      repeat (30) @(posedge clk);
      n = int'(sent) - nxt;
      chk1(n == lvl || n == lvl + 1, 1'b1);
      for (int i = 0; i < n; i++) begin
        #1 chk1(rts_n_out, 1'b1);
        hrd(OFS_RX_BUF, q);
        chk8(q, seed + 8'(nxt));
        nxt++;
      end
      chk1(rts_n_out, 1'b0);
    end
    hwr(OFS_FIFO_CTL, 8'hC1);
    @(posedge clk);
    obey <= 1'b0;
    go   <= 1'b1;
    for (n = 0; n < 400 && !(rx.first_data && sent == 8'(nxt + 15)); n++) @(posedge clk);
    go <= 1'b0;
    #1 chk1(rts_n_out, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk1(rts_n_out, 1'b1);
    repeat (20) @(posedge clk);
    chk8(sent - 8'(nxt), 8'd16);
    for (int i = 0; i < 16; i++) begin
      hrd(OFS_RX_BUF, q);
      chk8(q, seed + 8'(nxt));
      if (i == 0) chk1(rts_n_out, 1'b0);
      nxt++;
    end
    tend("auto rts");
    hwr(OFS_MODEM_CTL, 8'h20);
    @(posedge clk);
    pins.cts_n <= 1'b0;
    tx_more    <= 1'b1;
    n = int'(tx_cnt);
    repeat (46) @(posedge clk);
    chk8(tx_cnt - 8'(n), 8'd3);
    for (e1 = 0; e1 < 40 && tx.stop_mid !== 1'b1; e1++) @(posedge clk);
    repeat (5) @(posedge clk);
    pins.cts_n <= 1'b1;
    n = int'(tx_cnt);
    repeat (60) @(posedge clk);
    chk8(tx_cnt - 8'(n), 8'd1);
    chk1(tx_go, 1'b0);
    pins.cts_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk1(tx.busy, 1'b1);
    tx_more <= 1'b0;
    repeat (30) @(posedge clk);
    tend("auto cts");
    report_and_stop();
  end
endmodule // test_uart_autoflow_modem_host_if
`default_nettype wire
